// ==== verilog/trc_top.sv ====
/*
  Character path and pulse timing of the tape receiver control module:
  pin filters, an 8-word character buffer, punch priming, control character
  recognition and the sample, punch and feed derived pulses.
  Assumes the distributor holds the levels steady while the sample strobe is
  high, and that mode levels come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// pin filter: three flops, a change counts once stages two and three agree
module trc_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // shift chain; stage1 feeds stage2 only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept only a value seen on two successive samples
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= '0;
    end else if (stage2 == stage3) begin
      o_level <= stage3;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// character buffer with valid/ready on both sides; depth a power of two
module trc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != FULL_COUNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage needs no reset; empty flag guards stale words
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: character path and pulse timing
module trc_top #(
  parameter logic [trc_pkg::TRC_CNT_W-1:0] P_ADV_DELAY_CYC = trc_pkg::TRC_ADV_DELAY_CYC,
  parameter logic [trc_pkg::TRC_CNT_W-1:0] P_SECOND_DELAY_CYC = trc_pkg::TRC_SECOND_DELAY_CYC,
  parameter logic [trc_pkg::TRC_CNT_W-1:0] P_PUNCH_WIDTH_CYC = trc_pkg::TRC_PUNCH_WIDTH_CYC,
  parameter logic [trc_pkg::TRC_CNT_W-1:0] P_FEED_DELAY_CYC = trc_pkg::TRC_FEED_DELAY_CYC,
  parameter logic [trc_pkg::TRC_CNT_W-1:0] P_SET_A_DELAY_CYC = trc_pkg::TRC_SET_A_DELAY_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [trc_pkg::TRC_LEVELS-1:0] I_CHAR_LEVEL,
  input wire logic I_CHAR_STROBE,
  input wire logic I_FEED_WEB,
  input wire trc_pkg::trc_mode_t I_MODE,
  output logic O_CHAR_READY,
  output logic O_CHAR_LOST,
  output logic [trc_pkg::TRC_LEVELS-1:0] O_PUNCH_PRIME,
  output trc_pkg::trc_detect_t O_DETECT,
  output logic O_PROG_ADVANCE,
  output logic O_GATED_CLOCK,
  output logic O_PUNCH_SAMPLE,
  output logic O_SECOND_CLOCK,
  output logic O_FEED_COUNT_PULSE,
  output logic O_FEED_ALARM_PULSE,
  output logic O_SET_A_PULSE
);
  import trc_pkg::*;

  localparam logic [TRC_CNT_W-1:0] W = TRC_PULSE_WIDTH_CYC;
  localparam logic [TRC_CNT_W-1:0] ADV_END = P_ADV_DELAY_CYC + W;
  localparam logic [TRC_CNT_W-1:0] PUNCH_END = P_ADV_DELAY_CYC + P_PUNCH_WIDTH_CYC;
  localparam logic [TRC_CNT_W-1:0] SECOND_END = P_SECOND_DELAY_CYC + W;
  localparam logic [TRC_CNT_W-1:0] RUN_END =
    (PUNCH_END > SECOND_END) ? PUNCH_END : SECOND_END;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RUN = 2'b10
  } trc_char_state_t;

  typedef enum logic [4:0] {
    FD_IDLE = 5'b00001,
    FD_DELAY = 5'b00010,
    FD_PULSE = 5'b00100,
    FD_GAP = 5'b01000,
    FD_SET_A = 5'b10000
  } trc_feed_state_t;

  logic [TRC_LEVELS-1:0] level_f;
  logic strobe_f;
  logic web_f;
  logic strobe_d;
  logic web_d;
  logic strobe_rise;
  logic web_rise;
  logic buf_ready;
  logic buf_valid;
  logic [TRC_LEVELS-1:0] buf_data;
  logic pop;
  trc_char_state_t ch_state;
  logic [TRC_CNT_W-1:0] cnt;
  logic [TRC_LEVELS-1:0] cur_char;
  logic at_adv;
  logic in_adv;
  logic in_second;
  logic adv_gate;
  logic clk_gate;
  trc_detect_t raw_det;
  trc_detect_t next_det;
  logic [TRC_LEVELS-1:0] next_prime;
  logic feed_armed;
  trc_feed_state_t fd_state;
  logic [TRC_CNT_W-1:0] fcnt;

  //////////////////////////////////////////////////////////////////////////////
  // pin filters for levels, strobe and web sensor
  trc_pin_sync #(.WIDTH(TRC_LEVELS)) u_level_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_CHAR_LEVEL),
    .o_level(level_f)
  );

  trc_pin_sync #(.WIDTH(1)) u_strobe_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_CHAR_STROBE),
    .o_level(strobe_f)
  );

  trc_pin_sync #(.WIDTH(1)) u_web_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_FEED_WEB),
    .o_level(web_f)
  );

  // edge history of the filtered levels
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strobe_d <= 1'b0;
      web_d <= 1'b0;
    end else begin
      strobe_d <= strobe_f;
      web_d <= web_f;
    end
  end

  assign strobe_rise = strobe_f && !strobe_d;
  assign web_rise = web_f && !web_d;

  //////////////////////////////////////////////////////////////////////////////
  // characters queue here because a punch cycle outlasts a character time
  trc_fifo #(.WIDTH(TRC_LEVELS), .DEPTH(TRC_FIFO_DEPTH)) u_char_buf (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_in_valid(strobe_rise),
    .o_in_ready(buf_ready),
    .i_in_data(level_f),
    .o_out_valid(buf_valid),
    .i_out_ready(pop),
    .o_out_data(buf_data)
  );

  // room indication and lost-character pulse for the distributor side
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CHAR_READY <= 1'b0;
      O_CHAR_LOST <= 1'b0;
    end else begin
      O_CHAR_READY <= buf_ready;
      O_CHAR_LOST <= strobe_rise && !buf_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // character sequencer: one run of the timing chain per buffered character
  assign pop = (ch_state == CH_IDLE) && buf_valid;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ch_state <= CH_IDLE;
      cnt <= '0;
      cur_char <= TRC_NO_MARK;
    end else begin
      case (ch_state)
        CH_IDLE: begin
          cnt <= '0;
          if (buf_valid) begin
            cur_char <= buf_data;
            ch_state <= CH_RUN;
          end
        end
        CH_RUN: begin
          cnt <= cnt + 1'b1;
          if (cnt == RUN_END) begin
            ch_state <= CH_IDLE;
          end
        end
        default: begin
          ch_state <= CH_IDLE;
        end
      endcase
    end
  end

  // timing windows measured from the start of the run
  assign at_adv = (ch_state == CH_RUN) && (cnt == P_ADV_DELAY_CYC);
  assign in_adv = (ch_state == CH_RUN) && (cnt >= P_ADV_DELAY_CYC) && (cnt < ADV_END);
  assign in_second = (ch_state == CH_RUN) && (cnt >= P_SECOND_DELAY_CYC)
                     && (cnt < SECOND_END);
  assign adv_gate = !(I_MODE.delete_mode || I_MODE.incomplete_block);
  assign clk_gate = I_MODE.block_mode || I_MODE.delete_mode;

  // advance, gated clock and second clock pulses
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PROG_ADVANCE <= 1'b0;
      O_GATED_CLOCK <= 1'b0;
      O_SECOND_CLOCK <= 1'b0;
    end else begin
      O_PROG_ADVANCE <= in_adv && adv_gate;
      O_GATED_CLOCK <= in_adv && clk_gate;
      O_SECOND_CLOCK <= in_second;
    end
  end

  // punch sample one-shot, triggered by the gated clock unless block low
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PUNCH_SAMPLE <= 1'b0;
    end else if (at_adv && clk_gate && !I_MODE.block_num_low) begin
      O_PUNCH_SAMPLE <= 1'b1;
    end else if ((ch_state != CH_RUN) || (cnt == PUNCH_END)) begin
      O_PUNCH_SAMPLE <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // recogniser: exact match on all eight levels keeps the outputs exclusive
  always_comb begin
    raw_det.sender_ready_char = (cur_char == TRC_PAT_SENDER_READY);
    raw_det.end_of_block_char = (cur_char == TRC_PAT_END_OF_BLOCK);
    raw_det.block_num_one = (cur_char == TRC_PAT_BLOCK_ONE);
    raw_det.block_num_two = (cur_char == TRC_PAT_BLOCK_TWO);
    raw_det.block_num_three = (cur_char == TRC_PAT_BLOCK_THREE);
    next_det = TRC_NO_MARK[4:0];
    if (ch_state == CH_RUN) begin
      next_det = raw_det;
      if (!I_MODE.block_number_mode) begin
        next_det.block_num_one = 1'b0;
        next_det.block_num_two = 1'b0;
        next_det.block_num_three = 1'b0;
      end
    end
  end

  // punch primes: a 1 is a mark and punches a hole
  always_comb begin
    next_prime = cur_char;
    if (I_MODE.figs_prime) begin
      next_prime = TRC_ALL_MARK;
      next_prime[TRC_FIGS_SPACE_BIT] = 1'b0;
    end else if (I_MODE.delete_mode) begin
      next_prime = TRC_ALL_MARK;
    end
  end

  // primes hold the last character so the punch sees steady data
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PUNCH_PRIME <= TRC_NO_MARK;
      O_DETECT <= TRC_NO_MARK[4:0];
    end else begin
      O_PUNCH_PRIME <= next_prime;
      O_DETECT <= next_det;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // feed is armed by each punch so only one feed pulse follows a character
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      feed_armed <= 1'b0;
    end else if (at_adv && clk_gate && !I_MODE.block_num_low) begin
      feed_armed <= 1'b1;
    end else if (web_rise && (fd_state == FD_IDLE)) begin
      feed_armed <= 1'b0;
    end
  end

  // feed sequencer: delay, feed pulse, 1 ms interval, set A pulse
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fd_state <= FD_IDLE;
      fcnt <= '0;
    end else begin
      case (fd_state)
        FD_IDLE: begin
          fcnt <= '0;
          if (web_rise && feed_armed) begin
            fd_state <= FD_DELAY;
          end
        end
        FD_DELAY: begin
          fcnt <= fcnt + 1'b1;
          if (fcnt == P_FEED_DELAY_CYC - 1'b1) begin
            fcnt <= '0;
            fd_state <= FD_PULSE;
          end
        end
        FD_PULSE: begin
          fcnt <= fcnt + 1'b1;
          if (fcnt == W - 1'b1) begin
            fcnt <= '0;
            fd_state <= FD_GAP;
          end
        end
        FD_GAP: begin
          fcnt <= fcnt + 1'b1;
          if (fcnt == P_SET_A_DELAY_CYC - 1'b1) begin
            fcnt <= '0;
            fd_state <= FD_SET_A;
          end
        end
        FD_SET_A: begin
          fcnt <= fcnt + 1'b1;
          if (fcnt == W - 1'b1) begin
            fcnt <= '0;
            fd_state <= FD_IDLE;
          end
        end
        default: begin
          fd_state <= FD_IDLE;
        end
      endcase
    end
  end

  // feed pulse copies for the character counter and the feed alarm
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FEED_COUNT_PULSE <= 1'b0;
      O_FEED_ALARM_PULSE <= 1'b0;
      O_SET_A_PULSE <= 1'b0;
    end else begin
      O_FEED_COUNT_PULSE <= (fd_state == FD_PULSE);
      O_FEED_ALARM_PULSE <= (fd_state == FD_PULSE);
      O_SET_A_PULSE <= (fd_state == FD_SET_A);
    end
  end
endmodule

`default_nettype wire

// ==== common/trc_pkg.sv ====
/*
  Shared constants and carrier types for the tape receiver character path
  and pulse timing block.
  Assumes a single 125 MHz reference clock; all delays are counts of it.
*/
`default_nettype none
package trc_pkg;

  // clock period of the reference clock
  localparam int TRC_CLK_PERIOD_NS = 8;
  localparam int TRC_CNT_W = 20;
  localparam int TRC_LEVELS = 8;
  localparam int TRC_FIFO_DEPTH = 8;

  // documented times, in their own units
  localparam int TRC_ADV_DELAY_US = 50;
  localparam int TRC_PULSE_WIDTH_US = 10;
  localparam int TRC_SECOND_DELAY_US = 100;
  localparam int TRC_PUNCH_WIDTH_MS = 2;
  localparam int TRC_FEED_DELAY_US = 50;
  localparam int TRC_SET_A_DELAY_MS = 1;

  // cycle counts derived from the times; delays round up, widths round down
  localparam logic [TRC_CNT_W-1:0] TRC_ADV_DELAY_CYC =
    TRC_CNT_W'((TRC_ADV_DELAY_US * 1000 + TRC_CLK_PERIOD_NS - 1) / TRC_CLK_PERIOD_NS);
  localparam logic [TRC_CNT_W-1:0] TRC_PULSE_WIDTH_CYC =
    TRC_CNT_W'((TRC_PULSE_WIDTH_US * 1000) / TRC_CLK_PERIOD_NS);
  localparam logic [TRC_CNT_W-1:0] TRC_SECOND_DELAY_CYC =
    TRC_CNT_W'((TRC_SECOND_DELAY_US * 1000 + TRC_CLK_PERIOD_NS - 1) / TRC_CLK_PERIOD_NS);
  localparam logic [TRC_CNT_W-1:0] TRC_PUNCH_WIDTH_CYC =
    TRC_CNT_W'((TRC_PUNCH_WIDTH_MS * 1000000) / TRC_CLK_PERIOD_NS);
  localparam logic [TRC_CNT_W-1:0] TRC_FEED_DELAY_CYC =
    TRC_CNT_W'((TRC_FEED_DELAY_US * 1000 + TRC_CLK_PERIOD_NS - 1) / TRC_CLK_PERIOD_NS);
  localparam logic [TRC_CNT_W-1:0] TRC_SET_A_DELAY_CYC =
    TRC_CNT_W'((TRC_SET_A_DELAY_MS * 1000000 + TRC_CLK_PERIOD_NS - 1) / TRC_CLK_PERIOD_NS);

  // control character codes, bit n-1 is level n, 1 = marking (hole)
  localparam logic [7:0] TRC_PAT_SENDER_READY = 8'h71;
  localparam logic [7:0] TRC_PAT_END_OF_BLOCK = 8'hFE;
  localparam logic [7:0] TRC_PAT_BLOCK_ONE = 8'hA5;
  localparam logic [7:0] TRC_PAT_BLOCK_TWO = 8'h5A;
  localparam logic [7:0] TRC_PAT_BLOCK_THREE = 8'hC3;

  // punch prime forcing values
  localparam logic [7:0] TRC_ALL_MARK = 8'hFF;
  localparam int TRC_FIGS_SPACE_BIT = 3;
  localparam logic [7:0] TRC_NO_MARK = 8'h00;

  // programmer mode and condition levels from the surrounding logic
  typedef struct packed {
    logic block_mode;
    logic delete_mode;
    logic block_number_mode;
    logic figs_prime;
    logic incomplete_block;
    logic block_num_low;
  } trc_mode_t;

  // one flag per recognised control character
  typedef struct packed {
    logic sender_ready_char;
    logic end_of_block_char;
    logic block_num_one;
    logic block_num_two;
    logic block_num_three;
  } trc_detect_t;

endpackage
`default_nettype wire

// ==== dv/trc_far_model.sv ====
/*
  Far side model: receiving distributor and feed-hole sensor.
  Assumes the bench calls send_char and that punch samples reach it.
*/
`timescale 1ns/1ps
`default_nettype none
module trc_far_model (
  input wire logic i_clk,
  input wire logic i_punch_sample,
  input wire logic [7:0] i_feed_lag,
  output logic [7:0] o_level,
  output logic o_strobe,
  output logic o_web
);
  ////////////////////////////////////////
  // distributor: levels settle a clock early, strobe one bit time of 16 clocks
  task automatic send_char(input logic [7:0] c);
    @(negedge i_clk);
    o_level = c;
    @(negedge i_clk);
    o_strobe = 1'b1;
    repeat (16) @(negedge i_clk);
    o_strobe = 1'b0;
    o_level = ~c; // released levels must not look like the old char
    repeat (8) @(negedge i_clk);
  endtask

  initial begin
    o_level = 8'h00;
    o_strobe = 1'b0;
  end

  ////////////////////////////////////////
  // feed sensor: a web shows only once a punch moved the tape
  initial begin
    o_web = 1'b0;
    forever begin
      @(posedge i_punch_sample);
      repeat (i_feed_lag) @(negedge i_clk);
      o_web = 1'b1;
      repeat (20) @(negedge i_clk);
      o_web = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/trc_top_sva.sv ====
/*
  Checker for trc_top: pulse widths, spacing, gating and decode relations.
  Assumes it is bound to trc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module trc_top_sva #(
  parameter logic [19:0] P_ADV_DELAY_CYC = trc_pkg::TRC_ADV_DELAY_CYC,
  parameter logic [19:0] P_SECOND_DELAY_CYC = trc_pkg::TRC_SECOND_DELAY_CYC,
  parameter logic [19:0] P_PUNCH_WIDTH_CYC = trc_pkg::TRC_PUNCH_WIDTH_CYC,
  parameter logic [19:0] P_FEED_DELAY_CYC = trc_pkg::TRC_FEED_DELAY_CYC,
  parameter logic [19:0] P_SET_A_DELAY_CYC = trc_pkg::TRC_SET_A_DELAY_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire trc_pkg::trc_mode_t I_MODE,
  input wire logic [7:0] O_PUNCH_PRIME,
  input wire trc_pkg::trc_detect_t O_DETECT,
  input wire logic O_PROG_ADVANCE,
  input wire logic O_GATED_CLOCK,
  input wire logic O_PUNCH_SAMPLE,
  input wire logic O_SECOND_CLOCK,
  input wire logic O_FEED_COUNT_PULSE,
  input wire logic O_FEED_ALARM_PULSE,
  input wire logic O_SET_A_PULSE
);
  import trc_pkg::*;
  localparam int W = 1250;
  localparam int GAP = int'(P_SECOND_DELAY_CYC) - int'(P_ADV_DELAY_CYC);
  localparam int SA_LO = int'(P_SET_A_DELAY_CYC) - 1;
  localparam int SA_HI = int'(P_SET_A_DELAY_CYC) + 1;
  logic [1:0] up;
  logic [19:0] adv_len;
  logic [19:0] pun_len;
  logic [19:0] feed_len;

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  ////////////////////////////////////////
  // two clocks of history after reset, so $past never sees reset values
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      up <= 2'h0;
    end else begin
      up <= {up[0], 1'b1};
    end
  end

  // high-time counters, read on the falling edge of each pulse
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      adv_len <= 20'h00000;
      pun_len <= 20'h00000;
      feed_len <= 20'h00000;
    end else begin
      adv_len <= O_PROG_ADVANCE ? adv_len + 20'h00001 : 20'h00000;
      pun_len <= O_PUNCH_SAMPLE ? pun_len + 20'h00001 : 20'h00000;
      feed_len <= O_FEED_COUNT_PULSE ? feed_len + 20'h00001 : 20'h00000;
    end
  end

  ////////////////////////////////////////
  a_figs_prime: assert property (up[1] && I_MODE.figs_prime && $past(I_MODE.figs_prime)
    |-> O_PUNCH_PRIME == 8'hF7) else $error("figures prime wrong");
  a_delete_prime: assert property (up[1] && I_MODE.delete_mode
    && $past(I_MODE.delete_mode) && !I_MODE.figs_prime && !$past(I_MODE.figs_prime)
    |-> O_PUNCH_PRIME == 8'hFF) else $error("delete prime wrong");
  a_detect_single: assert property ($onehot0(O_DETECT))
    else $error("more than one detect");
  a_blknum_gate: assert property (!I_MODE.block_number_mode
    && !$past(I_MODE.block_number_mode)
    |-> {O_DETECT.block_num_one, O_DETECT.block_num_two, O_DETECT.block_num_three} == 3'h0)
    else $error("block number detect outside mode");
  a_adv_width: assert property ($fell(O_PROG_ADVANCE) |-> adv_len == W)
    else $error("advance width wrong");
  a_adv_suppress: assert property ($rose(O_PROG_ADVANCE)
    |-> !$past(I_MODE.delete_mode) && !$past(I_MODE.incomplete_block))
    else $error("advance not suppressed");
  a_gate_mode: assert property ($rose(O_GATED_CLOCK)
    |-> $past(I_MODE.block_mode) || $past(I_MODE.delete_mode))
    else $error("gated clock in wrong mode");
  a_punch_gate: assert property ($rose(O_PUNCH_SAMPLE)
    |-> $rose(O_GATED_CLOCK) && !$past(I_MODE.block_num_low))
    else $error("punch sample not gated");
  a_punch_width: assert property ($fell(O_PUNCH_SAMPLE) |-> pun_len == P_PUNCH_WIDTH_CYC)
    else $error("punch width wrong");
  a_second_gap: assert property ($rose(O_PUNCH_SAMPLE)
    |-> ##[GAP:GAP] $rose(O_SECOND_CLOCK)) else $error("second clock spacing wrong");
  a_feed_twin: assert property (O_FEED_COUNT_PULSE == O_FEED_ALARM_PULSE)
    else $error("feed outputs differ");
  a_feed_width: assert property ($fell(O_FEED_COUNT_PULSE) |-> feed_len == W)
    else $error("feed width wrong");
  a_set_a_delay: assert property ($fell(O_FEED_COUNT_PULSE)
    |-> ##[SA_LO:SA_HI] $rose(O_SET_A_PULSE)) else $error("set A delay wrong");
endmodule

bind trc_top trc_top_sva #(
  .P_ADV_DELAY_CYC(P_ADV_DELAY_CYC),
  .P_SECOND_DELAY_CYC(P_SECOND_DELAY_CYC),
  .P_PUNCH_WIDTH_CYC(P_PUNCH_WIDTH_CYC),
  .P_FEED_DELAY_CYC(P_FEED_DELAY_CYC),
  .P_SET_A_DELAY_CYC(P_SET_A_DELAY_CYC)
) chk_u (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_MODE(I_MODE),
  .O_PUNCH_PRIME(O_PUNCH_PRIME), .O_DETECT(O_DETECT), .O_PROG_ADVANCE(O_PROG_ADVANCE),
  .O_GATED_CLOCK(O_GATED_CLOCK), .O_PUNCH_SAMPLE(O_PUNCH_SAMPLE),
  .O_SECOND_CLOCK(O_SECOND_CLOCK), .O_FEED_COUNT_PULSE(O_FEED_COUNT_PULSE),
  .O_FEED_ALARM_PULSE(O_FEED_ALARM_PULSE), .O_SET_A_PULSE(O_SET_A_PULSE)
);
`default_nettype wire

// ==== dv/test_trc_top.sv ====
/*
  Self-checking bench for trc_top with shortened delays.
  Assumes the far side model drives the pins; modes are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module test_trc_top;
  import trc_pkg::*;
  localparam logic [19:0] ADV = 20'h00014;
  localparam logic [19:0] SEC = 20'h00028;
  localparam logic [19:0] PUN = 20'h0003C;
  localparam logic [19:0] SETA = 20'h0001E;
  localparam logic [19:0] FEED = 20'h0000A;
  logic clk, rst_n, strobe, web, o_ready, o_lost, o_adv, o_gate, o_punch, o_second, o_feed;
  logic o_alarm, o_seta, web_q;
  logic [7:0] lev, feed_lag, o_prime;
  logic [5:0] p;
  trc_mode_t mode;
  trc_detect_t o_det;
  int n_fail, total_checks, cyc, n_lost, web_at;
  int cnt [6], len [6], run [6], rise_at [6];

  trc_top #(.P_ADV_DELAY_CYC(ADV), .P_SECOND_DELAY_CYC(SEC), .P_PUNCH_WIDTH_CYC(PUN),
    .P_FEED_DELAY_CYC(FEED), .P_SET_A_DELAY_CYC(SETA)) dut_u (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CHAR_LEVEL(lev), .I_CHAR_STROBE(strobe),
    .I_FEED_WEB(web), .I_MODE(mode), .O_CHAR_READY(o_ready), .O_CHAR_LOST(o_lost),
    .O_PUNCH_PRIME(o_prime), .O_DETECT(o_det), .O_PROG_ADVANCE(o_adv), .O_GATED_CLOCK(o_gate),
    .O_PUNCH_SAMPLE(o_punch), .O_SECOND_CLOCK(o_second), .O_FEED_COUNT_PULSE(o_feed),
    .O_FEED_ALARM_PULSE(o_alarm), .O_SET_A_PULSE(o_seta));
  trc_far_model far_u (.i_clk(clk), .i_punch_sample(o_punch), .i_feed_lag(feed_lag),
    .o_level(lev), .o_strobe(strobe), .o_web(web));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////
  // pulse monitor: index 5 advance, 4 gated, 3 punch, 2 second, 1 feed, 0 set A
  assign p = {o_adv, o_gate, o_punch, o_second, o_feed, o_seta};
  always @(posedge clk) begin
    cyc++;
    if (o_lost === 1'b1) n_lost++;
    if (web === 1'b1 && web_q !== 1'b1) web_at = cyc; // sensor web start, for the feed lag
    web_q = web;
    for (int i = 0; i < 6; i++) begin
      if (p[i] === 1'b1) begin
        if (run[i] == 0) rise_at[i] = cyc;
        run[i]++;
      end else if (run[i] != 0) begin
        len[i] = run[i];
        cnt[i]++;
        run[i] = 0;
      end
    end
  end

  ////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_int(input string nm, input int e, input int g);
    total_checks++;
    if (g != e) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask

  // bounded waits: a pulse to rise, or 200 quiet clocks with room in the buffer
  task automatic wait_p(input int i);
    int k;
    for (k = 0; k < 300 && p[i] !== 1'b1; k++) @(negedge clk);
    if (p[i] !== 1'b1) begin
      n_fail++;
      $display("unexpected pulse %0d: expected 1, seen %b", i, p[i]);
      wrap_up();
    end
  endtask

  task automatic settle;
    int q, k;
    q = 0;
    for (k = 0; k < 20000 && q < 200; k++) begin
      @(negedge clk);
      q = (p === 6'h00 && o_ready === 1'b1) ? q + 1 : 0;
    end
    if (q < 200) begin
      n_fail++;
      $display("unexpected settle: expected idle, seen busy");
      wrap_up();
    end
  endtask

  ////////////////////////////////////////
  // one char per mode row: primes, pulse counts, widths and spacing
  task automatic t_modes;
    logic [5:0] rm [8] = '{6'h20, 6'h10, 6'h22, 6'h21, 6'h00, 6'h24, 6'h14, 6'h08};
    logic [1:0] rk [8] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0};
    logic [4:0] rd [8] = '{5'h1F, 5'h0F, 5'h0F, 5'h18, 5'h10, 5'h1F, 5'h0F, 5'h10};
    int b [6];
    int e;
    logic [7:0] c;
    logic [7:0] pe;
    for (int j = 0; j < 8; j++) begin
      c = {1'b0, 3'(j), 4'h6};
      b = cnt;
      feed_lag = j[0] ? 8'h96 : 8'h02; // prompt and slow tape feed
      @(negedge clk);
      mode = trc_mode_t'(rm[j]);
      far_u.send_char(c);
      wait_p(2);
      pe = rk[j] == 2'h0 ? c : (rk[j] == 2'h1 ? 8'hFF : 8'hF7);
      cmp_byte("prime", pe, o_prime);
      settle();
      for (int i = 0; i < 6; i++) begin
        e = i == 2 ? 1 : int'(rd[j][i > 2 ? i - 1 : i]);
        cmp_int("count", e, cnt[i] - b[i]);
        if (cnt[i] != b[i]) begin
          e = i == 3 ? int'(PUN) : 1250;
          cmp_int("width", e, len[i]);
          e = int'(SEC - ADV);
          if (i > 2) cmp_int("offset", e, rise_at[2] - rise_at[i]);
        end
      end
      // web to feed pulse: filter, edge and output latency of 6 clocks on top of the delay
      if (cnt[1] != b[1]) begin
        e = rise_at[1] - web_at - int'(FEED) - 6;
        cmp_int("feed_lag", 1, int'(e inside {[-1:1]}));
      end
      if (cnt[0] != b[0]) begin
        e = rise_at[0] - rise_at[1] - 1250 - int'(SETA);
        cmp_int("seta_gap", 1, int'(e inside {[-1:1]}));
      end
    end
  endtask

  // control character decode with and without block-number mode
  task automatic t_detect;
    logic [7:0] cd [7] = '{8'h71, 8'hFE, 8'hA5, 8'h5A, 8'hC3, 8'hFF, 8'hE5};
    logic [4:0] e;
    for (int m = 0; m < 2; m++) begin
      for (int j = 0; j < 7; j++) begin
        @(negedge clk);
        mode = trc_mode_t'({2'h0, m[0], 3'h0});
        far_u.send_char(cd[j]);
        wait_p(2);
        e = {cd[j] == 8'h71, cd[j] == 8'hFE, m[0] && cd[j] == 8'hA5, m[0] && cd[j] == 8'h5A,
          m[0] && cd[j] == 8'hC3};
        cmp_byte("detect", {3'h0, e}, {3'h0, o_det});
        cmp_byte("blknum", {5'h0, e[2:0]}, {5'h0, o_det[2:0]});
        settle();
      end
    end
  endtask

  // ten chars back to back: one runs, eight wait, the last is dropped
  task automatic t_buffer;
    int a, l;
    a = cnt[5];
    l = n_lost;
    @(negedge clk);
    mode = trc_mode_t'(6'h00);
    for (int j = 0; j < 10; j++) far_u.send_char(8'h06);
    cmp_int("lost", l + 1, n_lost);
    cmp_byte("ready", 8'h00, {7'h00, o_ready});
    settle();
    cmp_int("advances", a + 9, cnt[5]);
  endtask

  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    mode = trc_mode_t'(6'h00);
    feed_lag = 8'h02;
    repeat (2) @(negedge clk);
    cmp_byte("prime", 8'h00, o_prime);
    cmp_byte("ready", 8'h00, {7'h00, o_ready});
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp_byte("ready", 8'h01, {7'h00, o_ready});
    t_modes();
    t_detect();
    t_buffer();
    wrap_up();
  end
endmodule
`default_nettype wire
